// ==== common/ssr_pkg.sv ====
/*
 Constants, enumerations and carrier types of the status summary,
 service request and fault/inhibit port block.
 Assumes one command source on core_clk that issues one command a cycle.
*/
package ssr_pkg;

	// ==========================================================
	// Status byte and condition bit positions
	localparam int STB_QUES_BIT = 3;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_RQS_BIT = 6;
	localparam int STB_OPER_BIT = 7;
	localparam logic [7:0] STB_MSS_EXCL = 8'hBF;
	localparam int OPER_CC_BIT = 10;
	localparam int QUES_OV_BIT = 0;
	localparam int QUES_OC_BIT = 1;
	localparam int QUES_OT_BIT = 4;
	localparam int QUES_RI_BIT = 9;
	localparam int GRP_OPER = 0;
	localparam int GRP_QUES = 1;

	// ==========================================================
	// Reset values
	localparam logic [15:0] PTR_RST = 16'hFFFF;
	localparam logic [15:0] NTR_RST = 16'h0000;
	localparam logic [15:0] EN_RST = 16'h0000;
	localparam logic [7:0] SRE_RST = 8'h00;
	localparam logic [2:0] DIG_RST = 3'h0;

	// ==========================================================
	// Enumerations
	typedef enum logic [4:0] {
		OP_NOP, OP_W_OPER_PTR, OP_W_OPER_NTR, OP_W_OPER_EN,
		OP_W_QUES_PTR, OP_W_QUES_NTR, OP_W_QUES_EN, OP_W_SRE,
		OP_W_FLT_SRC, OP_W_FLT_EN, OP_W_RI_MODE, OP_W_FUNC, OP_W_DIG,
		OP_R_OPER_COND, OP_R_OPER_EVT, OP_R_QUES_COND, OP_R_QUES_EVT,
		OP_R_STB, OP_R_POLL, OP_R_MSG, OP_R_DIG
	} ssr_op_type;

	typedef enum logic [2:0] {
		FS_QUES, FS_OPER, FS_ESB, FS_RQS, FS_OFF
	} ssr_fsrc_type;

	typedef enum logic [1:0] {RI_LATCH, RI_LIVE, RI_OFF} ssr_ri_type;

	typedef enum logic {FN_INH_FAULT, FN_GENERAL_IO_FUNCTION} ssr_func_type;

	// ==========================================================
	// Command carrier
	typedef struct packed {
		logic valid;
		ssr_op_type op;
		logic [15:0] data;
	} ssr_cmd_type;

endpackage

// ==== src/ssr_status_core.sv ====
/*
 Status groups with transition filters, status byte, request logic,
 output message queue and the rear fault/inhibit/digital port.
 Assumes commands and the standard event summary come from logic on
 core_clk; condition bits and the port input are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_status_core
	import ssr_pkg::*;
#(
	parameter int QDEPTH = 16
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Command and answer
	input wire ssr_cmd_type cmd,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	// Condition sources
	input wire logic [15:0] oper_cond_in,
	input wire logic [15:0] ques_cond_in,
	input wire logic esb_in,
	input wire logic protect_clear,
	// Message queue fill side
	input wire logic mq_push,
	input wire logic [7:0] mq_byte,
	output logic mq_full,
	// Service request and inhibit state
	output logic srq,
	output logic remote_inhibit,
	// Rear port: bit 0/1 fault or outputs, bit 2 inhibit or in/out
	input wire logic port_in,
	output logic [2:0] port_out,
	output logic [2:0] port_oe
);

	localparam int AW = $clog2(QDEPTH);
	localparam int CW = $clog2(QDEPTH + 1);
	localparam logic [CW-1:0] QFULL = CW'(QDEPTH);

	// ==========================================================
	// Input synchronisers
	logic [15:0] meta_c [2];
	logic [15:0] sync_c [2];
	logic meta_p, sync_p;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_c <= '{default: '0};
			sync_c <= '{default: '0};
			meta_p <= 1'b1;
			sync_p <= 1'b1;
		end else if (clk_en) begin
			meta_c[GRP_OPER] <= oper_cond_in;
			meta_c[GRP_QUES] <= ques_cond_in;
			sync_c <= meta_c;
			meta_p <= port_in;
			sync_p <= meta_p;
		end
	end

	// ==========================================================
	// Status groups
	logic [15:0] cond [2];
	logic [15:0] evt_q [2];
	logic [15:0] prev_q [2];
	logic [15:0] ptr_q [2];
	logic [15:0] ntr_q [2];
	logic [1:0] grp_sum;

	assign cond[GRP_OPER] = sync_c[GRP_OPER];
	assign cond[GRP_QUES] = sync_c[GRP_QUES]
		| (16'(remote_inhibit) << QUES_RI_BIT);

	for (genvar g = 0; g < 2; g++) begin : grp
		localparam ssr_op_type W_PTR = g ? OP_W_QUES_PTR : OP_W_OPER_PTR;
		localparam ssr_op_type W_NTR = g ? OP_W_QUES_NTR : OP_W_OPER_NTR;
		localparam ssr_op_type W_EN = g ? OP_W_QUES_EN : OP_W_OPER_EN;
		localparam ssr_op_type R_EVT = g ? OP_R_QUES_EVT : OP_R_OPER_EVT;
		logic [15:0] prev, ptr, fall_filter, en, evt;
		logic [15:0] next_ptr, next_ntr, next_en, next_evt;

		always_comb begin
			next_ptr = (cmd.valid && cmd.op == W_PTR) ? cmd.data : ptr;
			next_ntr = (cmd.valid && cmd.op == W_NTR) ? cmd.data : fall_filter;
			next_en = (cmd.valid && cmd.op == W_EN) ? cmd.data : en;
			next_evt = (cmd.valid && cmd.op == R_EVT) ? '0 : evt;
			next_evt = next_evt | (cond[g] & ~prev & ptr)
				| (~cond[g] & prev & fall_filter);
		end

		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				prev <= '0;
				ptr <= PTR_RST;
				fall_filter <= NTR_RST;
				en <= EN_RST;
				evt <= '0;
			end else if (clk_en) begin
				prev <= cond[g];
				ptr <= next_ptr;
				fall_filter <= next_ntr;
				en <= next_en;
				evt <= next_evt;
			end
		end

		assign grp_sum[g] = |(evt & en);
		assign evt_q[g] = evt;
		assign prev_q[g] = prev;
		assign ptr_q[g] = ptr;
		assign ntr_q[g] = fall_filter;
	end

	// ==========================================================
	// Message queue
	logic [7:0] mq_mem [QDEPTH];
	logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
	logic [CW-1:0] cnt, next_cnt;
	logic do_push, do_pop;

	always_comb begin
		do_push = mq_push && cnt != QFULL;
		do_pop = cmd.valid && cmd.op == OP_R_MSG && cnt != '0;
		next_wptr = wptr;
		next_rptr = rptr;
		if (do_push) begin
			next_wptr = (wptr == AW'(QDEPTH - 1)) ? '0 : wptr + 1'b1;
		end
		if (do_pop) begin
			next_rptr = (rptr == AW'(QDEPTH - 1)) ? '0 : rptr + 1'b1;
		end
		next_cnt = cnt + CW'(do_push) - CW'(do_pop);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr <= '0;
			rptr <= '0;
			cnt <= '0;
			mq_full <= 1'b0;
		end else if (clk_en) begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			cnt <= next_cnt;
			mq_full <= next_cnt == QFULL;
		end
	end

	always_ff @(posedge core_clk) begin
		if (clk_en && do_push) begin
			mq_mem[wptr] <= mq_byte;
		end
	end

	// ==========================================================
	// Status byte, request and port control
	logic [7:0] sre, next_sre, stb, stb_query;
	logic mss, mss_prev, next_rqs;
	ssr_fsrc_type fsrc, next_fsrc;
	ssr_ri_type rimode, next_rimode;
	ssr_func_type func, next_func;
	logic fen, next_fen, ri_latch, next_ri_latch, inh_now;
	logic next_ri, fault_want;
	logic [2:0] dig, next_dig, next_out, next_oe;
	logic next_rsp_valid;
	logic [15:0] next_rsp_data;
	logic poll;

	always_comb begin
		stb = '0;
		stb[STB_QUES_BIT] = grp_sum[GRP_QUES];
		stb[STB_MAV_BIT] = cnt != '0;
		stb[STB_ESB_BIT] = esb_in;
		stb[STB_OPER_BIT] = grp_sum[GRP_OPER];
		stb[STB_RQS_BIT] = srq;
		mss = |(stb & sre & STB_MSS_EXCL);
		stb_query = stb;
		stb_query[STB_RQS_BIT] = mss;
		poll = cmd.valid && cmd.op == OP_R_POLL;
		// Set wins over the poll's clear
		next_rqs = (mss && !mss_prev) || (srq && !poll);
	end

	always_comb begin
		next_sre = sre;
		next_fsrc = fsrc;
		next_fen = fen;
		next_rimode = rimode;
		next_func = func;
		next_dig = dig;
		if (cmd.valid) begin
			unique case (cmd.op)
				OP_W_SRE: next_sre = cmd.data[7:0];
				OP_W_FLT_SRC: next_fsrc = ssr_fsrc_type'(cmd.data[2:0]);
				OP_W_FLT_EN: next_fen = cmd.data[0];
				OP_W_RI_MODE: next_rimode = ssr_ri_type'(cmd.data[1:0]);
				OP_W_FUNC: next_func = ssr_func_type'(cmd.data[0]);
				OP_W_DIG: next_dig = cmd.data[2:0];
				default: next_sre = sre;
			endcase
		end
	end

	always_comb begin
		inh_now = func == FN_INH_FAULT && !sync_p;
		next_ri_latch = ri_latch;
		unique case (rimode)
			RI_LATCH: begin
				next_ri_latch = inh_now || (ri_latch && !protect_clear);
				next_ri = next_ri_latch;
			end
			RI_LIVE: next_ri = inh_now;
			default: next_ri = 1'b0;
		endcase
		unique case (fsrc)
			FS_QUES: fault_want = grp_sum[GRP_QUES];
			FS_OPER: fault_want = grp_sum[GRP_OPER];
			FS_ESB: fault_want = esb_in;
			FS_RQS: fault_want = srq;
			default: fault_want = 1'b0;
		endcase
		fault_want = fault_want && fen;
		if (func == FN_INH_FAULT) begin
			next_out = 3'h0;
			next_oe = {1'b0, {2{fault_want}}};
		end else begin
			next_out = {1'b0, dig[1:0]};
			next_oe = {!dig[2], 2'b11};
		end
	end

	always_comb begin
		next_rsp_valid = 1'b0;
		next_rsp_data = '0;
		if (cmd.valid) begin
			next_rsp_valid = 1'b1;
			unique case (cmd.op)
				OP_R_OPER_COND: next_rsp_data = cond[GRP_OPER];
				OP_R_OPER_EVT: next_rsp_data = evt_q[GRP_OPER];
				OP_R_QUES_COND: next_rsp_data = cond[GRP_QUES];
				OP_R_QUES_EVT: next_rsp_data = evt_q[GRP_QUES];
				OP_R_STB: next_rsp_data = {8'h00, stb_query};
				OP_R_POLL: next_rsp_data = {8'h00, stb};
				OP_R_MSG: next_rsp_data = {8'h00, mq_mem[rptr]};
				OP_R_DIG: next_rsp_data = {13'h0000, sync_p, dig[1:0]};
				default: next_rsp_valid = 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sre <= SRE_RST;
			fsrc <= FS_OFF;
			fen <= 1'b0;
			rimode <= RI_OFF;
			func <= FN_INH_FAULT;
			dig <= DIG_RST;
			ri_latch <= 1'b0;
			remote_inhibit <= 1'b0;
			srq <= 1'b0;
			mss_prev <= 1'b0;
			port_out <= 3'h0;
			port_oe <= 3'h0;
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
		end else if (clk_en) begin
			sre <= next_sre;
			fsrc <= next_fsrc;
			fen <= next_fen;
			rimode <= next_rimode;
			func <= next_func;
			dig <= next_dig;
			ri_latch <= next_ri_latch;
			remote_inhibit <= next_ri;
			srq <= next_rqs;
			mss_prev <= mss;
			port_out <= next_out;
			port_oe <= next_oe;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_stb_query_mss: assert property (clk_en && cmd.valid
		&& cmd.op == OP_R_STB |=> rsp_valid
		&& rsp_data[7:0] == $past(stb_query) && ($past(srq) -> srq))
		else $error("status query answer or request bit wrong");
	a_poll_clears_rqs: assert property (clk_en && poll
		&& !(mss && !mss_prev) |=> !srq
		&& rsp_data[STB_RQS_BIT] == $past(srq))
		else $error("serial poll did not return and clear");
	a_mss_masked: assert property ((stb & sre & STB_MSS_EXCL) == 8'h00
		|-> !mss) else $error("summary set with nothing enabled");
	a_rise_sets_srq: assert property (clk_en && mss && !mss_prev
		|=> srq ##1 (srq || $past(poll)))
		else $error("new request not latched");
	a_mav_tracks_queue: assert property (stb[STB_MAV_BIT] == (cnt != '0)
		&& (mq_full -> cnt == QFULL))
		else $error("queue flag mismatch");
	a_evt_read_clears: assert property (clk_en && cmd.valid
		&& cmd.op == OP_R_OPER_EVT && cond[GRP_OPER] == prev_q[GRP_OPER]
		|=> evt_q[GRP_OPER] == 16'h0000)
		else $error("event read did not clear");
	a_cc_rise_latch: assert property (clk_en && cond[GRP_OPER][OPER_CC_BIT]
		&& !prev_q[GRP_OPER][OPER_CC_BIT] && ptr_q[GRP_OPER][OPER_CC_BIT]
		|=> evt_q[GRP_OPER][OPER_CC_BIT])
		else $error("rising edge not latched");
	a_fall_latch: assert property (clk_en && !cond[GRP_QUES][QUES_OC_BIT]
		&& prev_q[GRP_QUES][QUES_OC_BIT] && ntr_q[GRP_QUES][QUES_OC_BIT]
		|=> evt_q[GRP_QUES][QUES_OC_BIT])
		else $error("falling edge not latched");
	a_fault_drive: assert property (clk_en && func == FN_INH_FAULT
		|=> port_oe[1:0] == {2{$past(fault_want)}} && port_out == 3'h0)
		else $error("fault pin drive wrong");

	c_poll_request: cover property (srq && clk_en && poll);
	c_fault_low: cover property (port_oe[0] && func == FN_INH_FAULT);
	c_queue_full: cover property (mq_full);
	c_inhibit_latched: cover property (remote_inhibit && rimode == RI_LATCH);

endmodule

`default_nettype wire

// ==== verif/ssr_far_side.sv ====
/*
 Far side of the rear port: pull-ups on the fault and inhibit lines
 and an external inhibit switch that sinks the inhibit line.
 Assumes the port lines are open collector with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_far_side (
	// Device port drive
	input wire logic [2:0] port_out,
	input wire logic [2:0] port_oe,
	// External inhibit switch
	input wire logic inhibit_req,
	// Resolved line levels
	output logic port_in,
	output logic [2:0] pin_level
);
	// ==========================================================
	// Line resolution: a released line floats up to its pull-up
	always_comb begin
		pin_level[0] = !(port_oe[0] && !port_out[0]);
		pin_level[1] = !(port_oe[1] && !port_out[1]);
		pin_level[2] = !((port_oe[2] && !port_out[2]) || inhibit_req);
		port_in = pin_level[2];
	end
endmodule

`default_nettype wire

// ==== verif/tb_status_service_request_fault_port.sv ====
/*
 Self-checking bench of the status, request and fault port block.
 Assumes ssr_pkg and the far side model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_status_service_request_fault_port
	import ssr_pkg::*;
;
	logic core_clk, rst_n, clk_en, esb_in, protect_clear, mq_push, inh_req;
	ssr_cmd_type cmd;
	logic [15:0] oper_cond_in, ques_cond_in, rsp_data, rd;
	logic [7:0] mq_byte, b;
	logic rsp_valid, mq_full, srq, remote_inhibit, port_in;
	logic [2:0] port_out, port_oe, pin_level;
	logic [7:0] q[$];
	int num_errors, n_compared, seed;
	int qb[3] = '{QUES_OV_BIT, QUES_OC_BIT, QUES_OT_BIT};
	ssr_ri_type modes[3] = '{RI_LATCH, RI_LIVE, RI_OFF};

	ssr_status_core #(.QDEPTH(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(clk_en), .cmd(cmd), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .oper_cond_in(oper_cond_in),
		.ques_cond_in(ques_cond_in), .esb_in(esb_in),
		.protect_clear(protect_clear), .mq_push(mq_push),
		.mq_byte(mq_byte), .mq_full(mq_full), .srq(srq),
		.remote_inhibit(remote_inhibit), .port_in(port_in),
		.port_out(port_out), .port_oe(port_oe));
	ssr_far_side far (.port_out(port_out), .port_oe(port_oe),
		.inhibit_req(inh_req), .port_in(port_in), .pin_level(pin_level));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] stb_exp(logic qs, ma, op_s,
		logic [7:0] sre);
		logic [7:0] s;
		s = '0;
		s[STB_QUES_BIT] = qs;
		s[STB_MAV_BIT] = ma;
		s[STB_OPER_BIT] = op_s;
		s[STB_RQS_BIT] = |(s & sre);
		return {8'h00, s};
	endfunction

	task automatic chk(input string name, input logic [15:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic op(input ssr_op_type o, input logic [15:0] d);
		cmd = '{1'b1, o, d};
		@(posedge core_clk) #1;
		chk("answer valid", 16'(o >= OP_R_OPER_COND), 16'(rsp_valid));
		rd = rsp_data;
		cmd = '0;
		@(posedge core_clk) #1;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic end_of_test();
		$display("Compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		num_errors++;
		end_of_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'h9EF0;
		{rst_n, esb_in, protect_clear, mq_push, inh_req} = '0;
		clk_en = 1'b1;
		cmd = '0;
		{oper_cond_in, ques_cond_in, mq_byte} = '0;
		repeat (3) @(posedge core_clk);
		#1 rst_n = 1'b1;
		chk("srq", 16'h0, 16'(srq));
		chk("port oe", 16'h0, 16'(port_oe));
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(0, 0, 0, 8'h00), rd);
		op(OP_W_OPER_NTR, 16'h0400);
		op(OP_W_OPER_EN, 16'h0400);
		op(OP_W_SRE, 16'h0080);
		op(OP_W_OPER_PTR, 16'h0400);
		oper_cond_in = ($random(seed) & 16'hFBFF) | 16'h0400;
		cyc(6);
		chk("srq", 16'h1, 16'(srq));
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(0, 0, 1, 8'h80), rd);
		op(OP_R_POLL, 16'h0);
		chk("poll bit6", 16'h1, 16'(rd[6]));
		chk("srq", 16'h0, 16'(srq));
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(0, 0, 1, 8'h80), rd);
		op(OP_R_OPER_EVT, 16'h0);
		chk("oper event", 16'h0400, rd);
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(0, 0, 0, 8'h80), rd);
		oper_cond_in = $random(seed) & 16'hFBFF;
		cyc(6);
		chk("srq", 16'h1, 16'(srq));
		op(OP_R_OPER_EVT, 16'h0);
		chk("oper event", 16'h0400, rd);
		op(OP_R_POLL, 16'h0);
		chk("poll bit6", 16'h1, 16'(rd[6]));
		// ======================================================
		// Questionable group and fault output
		op(OP_W_QUES_EN, 16'h0013);
		op(OP_W_SRE, 16'h0008);
		op(OP_W_FLT_SRC, 16'(FS_QUES));
		op(OP_W_FLT_EN, 16'h0001);
		foreach (qb[i]) begin
			ques_cond_in = 16'h0001 << qb[i];
			cyc(6);
			op(OP_R_STB, 16'h0);
			chk("status", stb_exp(1, 0, 0, 8'h08), rd);
			chk("fault oe", 16'h3, 16'(port_oe[1:0]));
			chk("fault out", 16'h0, 16'(port_out[1:0]));
			ques_cond_in = 16'h0;
			cyc(6);
			chk("fault oe", 16'h3, 16'(port_oe[1:0]));
			op(OP_R_QUES_EVT, 16'h0);
			chk("ques event", 16'h0001 << qb[i], rd);
			op(OP_R_POLL, 16'h0);
			chk("poll bit6", 16'h1, 16'(rd[6]));
			chk("fault oe", 16'h0, 16'(port_oe[1:0]));
		end
		op(OP_W_QUES_EN, 16'h0);
		ques_cond_in = 16'h0002;
		cyc(6);
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(0, 0, 0, 8'h08), rd);
		chk("fault oe", 16'h0, 16'(port_oe[1:0]));
		op(OP_W_QUES_EN, 16'h0002);
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(1, 0, 0, 8'h08), rd);
		chk("fault oe", 16'h3, 16'(port_oe[1:0]));
		op(OP_W_FLT_EN, 16'h0);
		chk("fault oe", 16'h0, 16'(port_oe[1:0]));
		op(OP_W_SRE, 16'h0);
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(1, 0, 0, 8'h00), rd);
		ques_cond_in = 16'h0;
		op(OP_R_QUES_EVT, 16'h0);
		chk("ques event", 16'h0002, rd);
		// ======================================================
		// Output queue
		repeat (4) begin
			b = 8'($random(seed));
			q.push_back(b);
			mq_byte = b;
			mq_push = 1'b1;
			cyc(1);
			mq_push = 1'b0;
			cyc(1);
		end
		chk("queue full", 16'h1, 16'(mq_full));
		// Push while full is dropped
		mq_byte = 8'hA5;
		mq_push = 1'b1;
		cyc(1);
		mq_push = 1'b0;
		cyc(1);
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(0, 1, 0, 8'h00), rd);
		while (q.size() > 0) begin
			op(OP_R_MSG, 16'h0);
			chk("message", 16'(q.pop_front()), rd);
		end
		op(OP_R_STB, 16'h0);
		chk("status", stb_exp(0, 0, 0, 8'h00), rd);
		chk("queue full", 16'h0, 16'(mq_full));
		// ======================================================
		// Request and standard event fault sources
		op(OP_W_FLT_EN, 16'h0001);
		op(OP_W_FLT_SRC, 16'(FS_RQS));
		chk("fault oe", 16'h3, 16'(port_oe[1:0]));
		op(OP_R_POLL, 16'h0);
		chk("fault oe", 16'h0, 16'(port_oe[1:0]));
		esb_in = 1'b1;
		op(OP_W_FLT_SRC, 16'(FS_ESB));
		chk("fault oe", 16'h3, 16'(port_oe[1:0]));
		esb_in = 1'b0;
		cyc(2);
		chk("fault oe", 16'h0, 16'(port_oe[1:0]));
		op(OP_W_FLT_EN, 16'h0);
		// ======================================================
		// Remote inhibit modes, then digital port
		foreach (modes[i]) begin
			op(OP_W_RI_MODE, 16'(modes[i]));
			inh_req = 1'b1;
			cyc(6);
			chk("inhibit", 16'(modes[i] != RI_OFF), 16'(remote_inhibit));
			inh_req = 1'b0;
			cyc(6);
			chk("inhibit", 16'(modes[i] == RI_LATCH), 16'(remote_inhibit));
			protect_clear = 1'b1;
			cyc(1);
			protect_clear = 1'b0;
			cyc(3);
			chk("inhibit", 16'h0, 16'(remote_inhibit));
		end
		op(OP_W_FUNC, 16'(FN_GENERAL_IO_FUNCTION));
		for (int d = 0; d < 8; d++) begin
			op(OP_W_DIG, 16'(d));
			cyc(3);
			chk("port out", 16'(d & 3), 16'(port_out));
			chk("port oe", 16'({~d[2], 2'b11}), 16'(port_oe));
			op(OP_R_DIG, 16'h0);
			chk("pin 2", 16'(d[2]), 16'(rd[2]));
		end
		end_of_test();
	end
endmodule

`default_nettype wire
